// [rsc_clock_control.sv]
// Radio and system clock control registers with AXI4-Lite access
`default_nettype none
module rsc_clock_control
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Reference enables on this clock
  input wire logic div1_tick_in,
  input wire logic fixed_sixteen_mhz_clock_in,
  // Asynchronous status pins
  input wire logic crystal_settled_in,
  input wire logic pll_locked_in,
  input wire logic lowpower_clock_ok_in,
  input wire logic debugger_en_in,
  // Link core
  input wire logic link_core_sleep_in,
  input wire logic link_reg_access_in,
  output logic hard_fault_out,
  output logic link_core_clock_gate_out,
  output logic link_core_tick_out,
  output logic link_lowpower_timer_reset_out,
  // RF control unit
  output logic rf_unit_clock_gate_out,
  output logic rf_unit_tick_out,
  // Clock source controls
  output logic [1:0] system_clock_select_out,
  output logic [1:0] lowpower_clock_select_out,
  output logic fixed_sixteen_mhz_clock_halve_for_big_crystal_out,
  output logic pll_halve_out,
  output logic usb_clock_select_out,
  output logic crystal_divider_enable_out,
  output logic crystal_osc_off_out,
  // Timers and misc clocks
  output logic timer1_pwm_pad_route_out,
  output logic timer2_tick_out,
  output logic wakeup_counter_clock_gate_out,
  output logic breathing_led_clock_gate_out
);
  // ****************************************
  // Bus slave
  // ****************************************
  localparam logic [WORD_ADDR_W-1:0] RADIO_WORD = RADIO_CLOCK_CTRL_IDX[WORD_ADDR_W-1:0];
  localparam logic [WORD_ADDR_W-1:0] SYSTEM_WORD = SYSTEM_CLOCK_CTRL_IDX[WORD_ADDR_W-1:0];
  localparam logic [WORD_ADDR_W-1:0] TIMER_WORD = TIMER_CLOCK_CTRL_IDX[WORD_ADDR_W-1:0];

  logic [11:0] awaddr_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire;
  logic we_radio;
  logic we_system;
  logic we_timer;
  logic wr_hit;
  logic [15:0] radio_ff;
  logic [15:0] system_ff;
  logic [15:0] timer_ff;
  logic [15:0] system_rd;
  logic [15:0] rd_word;
  logic rd_hit;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] upd;
    upd = old;
    if (strb[0]) begin
      upd[7:0] = data[7:0];
    end
    if (strb[1]) begin
      upd[15:8] = data[15:8];
    end
    merge16 = (upd & mask) | (old & ~mask);
  endfunction

  assign s_axi_awready_out = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready_out = !w_have_ff && !bvalid_ff;
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign we_radio = wr_fire && (awaddr_ff[11:2] == RADIO_WORD);
  assign we_system = wr_fire && (awaddr_ff[11:2] == SYSTEM_WORD);
  assign we_timer = wr_fire && (awaddr_ff[11:2] == TIMER_WORD);
  assign wr_hit = we_radio || we_system || we_timer;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_ff <= 1'b0;
      awaddr_ff <= 12'h000;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_have_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_ff <= 1'b1;
      wdata_ff <= s_axi_wdata_in;
      wstrb_ff <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;

  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    if (s_axi_araddr_in[11:2] == RADIO_WORD) begin
      rd_word = radio_ff;
    end else if (s_axi_araddr_in[11:2] == SYSTEM_WORD) begin
      rd_word = system_rd;
    end else if (s_axi_araddr_in[11:2] == TIMER_WORD) begin
      rd_word = timer_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready_out = !rvalid_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_DECERR;
      rdata_ff <= {16'h0000, rd_word};
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      radio_ff <= RADIO_CLOCK_CTRL_RST;
    end else if (we_radio) begin
      radio_ff <= merge16(radio_ff, wdata_ff, wstrb_ff, RADIO_CLOCK_CTRL_MASK);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      system_ff <= SYSTEM_CLOCK_CTRL_RST;
    end else if (we_system) begin
      system_ff <= merge16(system_ff, wdata_ff, wstrb_ff, SYSTEM_CLOCK_CTRL_MASK);
    end
  end

  // rst_n_in clears this to TIMER_CLOCK_CTRL_RST (zero), while radio and system reload nonzero values, so pad routing does not survive a reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_ff <= TIMER_CLOCK_CTRL_RST;
    end else if (we_timer) begin
      timer_ff <= merge16(timer_ff, wdata_ff, wstrb_ff, TIMER_CLOCK_CTRL_MASK);
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sync_a_ff;
  logic [3:0] sync_b_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a_ff <= 4'h0;
      sync_b_ff <= 4'h0;
    end else begin
      sync_a_ff <= {debugger_en_in, lowpower_clock_ok_in, pll_locked_in, crystal_settled_in};
      sync_b_ff <= sync_a_ff;
    end
  end

  // ****************************************
  // System clock source handover
  // ****************************************
  logic [1:0] active_src_ff;
  logic [1:0] sel_src;
  logic target_ok;
  assign sel_src = system_ff[SYS_SEL_LSB+1:SYS_SEL_LSB];

  always_comb begin
    unique case (sel_src)
      SRC_CRYSTAL: target_ok = sync_b_ff[0] && !system_ff[XTAL_OFF_BIT];
      SRC_RC_FAST: target_ok = 1'b1;
      SRC_LOWPOWER: target_ok = sync_b_ff[2];
      SRC_PLL: target_ok = sync_b_ff[1];
    endcase
  end

  // Stay on the old source until the new one is up, never switch to a clock that is not ready
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_src_ff <= SRC_RC_FAST;
    end else if (target_ok) begin
      active_src_ff <= sel_src;
    end
  end
  assign system_clock_select_out = active_src_ff;

  always_comb begin
    system_rd = system_ff & SYSTEM_CLOCK_CTRL_MASK;
    system_rd[RUN_PLL_BIT] = (active_src_ff == SRC_PLL);
    system_rd[RUN_CRYSTAL_BIT] = (active_src_ff == SRC_CRYSTAL);
    system_rd[RUN_RC_BIT] = (active_src_ff == SRC_RC_FAST);
    system_rd[RUN_SLOW_BIT] = (active_src_ff == SRC_LOWPOWER);
  end

  // Direct register bits; the crystal stops the moment its bit is written
  assign lowpower_clock_select_out = system_ff[LP_SEL_LSB+1:LP_SEL_LSB];
  assign fixed_sixteen_mhz_clock_halve_for_big_crystal_out = system_ff[FIXED_SIXTEEN_MHZ_CLOCK_HALVE_BIT];
  assign pll_halve_out = system_ff[PLL_HALVE_BIT];
  assign usb_clock_select_out = system_ff[USB_SEL_BIT];
  assign crystal_divider_enable_out = system_ff[XTAL_DIV_EN_BIT];
  assign crystal_osc_off_out = system_ff[XTAL_OFF_BIT];

  // ****************************************
  // Reference path and dividers
  // ****************************************
  logic fixed_sixteen_mhz_clock_phase_ff;
  logic fixed_sixteen_mhz_clock_eff;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fixed_sixteen_mhz_clock_phase_ff <= 1'b0;
    end else if (fixed_sixteen_mhz_clock_in) begin
      fixed_sixteen_mhz_clock_phase_ff <= !fixed_sixteen_mhz_clock_phase_ff;
    end
  end
  assign fixed_sixteen_mhz_clock_eff = fixed_sixteen_mhz_clock_in && (!system_ff[FIXED_SIXTEEN_MHZ_CLOCK_HALVE_BIT] || fixed_sixteen_mhz_clock_phase_ff);

  logic link_core_on;
  assign link_core_on = radio_ff[LINK_GATE_BIT] && !link_core_sleep_in;
  assign link_core_clock_gate_out = radio_ff[LINK_GATE_BIT];
  assign rf_unit_clock_gate_out = radio_ff[RF_GATE_BIT];
  assign link_lowpower_timer_reset_out = radio_ff[LINK_LP_RESET_BIT];
  assign wakeup_counter_clock_gate_out = timer_ff[WAKEUP_GATE_BIT];
  assign breathing_led_clock_gate_out = timer_ff[BREATH_GATE_BIT];

  rsc_div_if link_div ();
  rsc_div_if rf_div ();
  rsc_div_if tmr2_div ();
  assign link_div.src_tick = fixed_sixteen_mhz_clock_eff;
  assign link_div.en = link_core_on;
  assign link_div.code = radio_ff[LINK_DIV_LSB+1:LINK_DIV_LSB];
  assign rf_div.src_tick = fixed_sixteen_mhz_clock_eff;
  assign rf_div.en = radio_ff[RF_GATE_BIT];
  assign rf_div.code = radio_ff[RF_DIV_LSB+1:RF_DIV_LSB];
  assign tmr2_div.src_tick = timer_ff[TMR2_SEL_BIT] ? div1_tick_in : fixed_sixteen_mhz_clock_eff;
  assign tmr2_div.en = timer_ff[TMR2_GATE_BIT];
  assign tmr2_div.code = DIV_BY_ONE;

  rsc_divider u_link_div (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .div_io(link_div));
  rsc_divider u_rf_div (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .div_io(rf_div));
  rsc_divider u_tmr2_div (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .div_io(tmr2_div));
  assign link_core_tick_out = link_div.tick;
  assign rf_unit_tick_out = rf_div.tick;
  assign timer2_tick_out = tmr2_div.tick;

  // ****************************************
  // Hard fault and pad routing
  // ****************************************
  logic hard_fault_ff;
  logic pad_route_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hard_fault_ff <= 1'b0;
    end else begin
      hard_fault_ff <= link_reg_access_in && !link_core_on;
    end
  end
  assign hard_fault_out = hard_fault_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_route_ff <= 1'b0;
    end else begin
      pad_route_ff <= timer_ff[PWM_ROUTE_BIT] && !sync_b_ff[3];
    end
  end
  assign timer1_pwm_pad_route_out = pad_route_ff;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_radio_write;
    we_radio && wstrb_ff[0];
  endsequence
  sequence s_system_write;
    we_system && wstrb_ff[0];
  endsequence

  a_fault_when_stopped: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    link_reg_access_in && !(radio_ff[LINK_GATE_BIT] && !link_core_sleep_in) |=> hard_fault_out)
    else $error("no hard fault on access to stopped link core");
  a_no_fault_running: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    hard_fault_out |-> $past(link_reg_access_in) && !$past(link_core_on))
    else $error("hard fault without a stopped-clock access");
  a_lp_reset_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_radio_write ##0 wdata_ff[LINK_LP_RESET_BIT] |=> link_lowpower_timer_reset_out)
    else $error("low-power timer reset did not follow write");
  a_xtal_off_now: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_system_write ##0 wdata_ff[XTAL_OFF_BIT] |=> crystal_osc_off_out)
    else $error("crystal not stopped one cycle after write");
  a_run_flag_onehot: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $onehot(system_rd[RUN_PLL_BIT:RUN_SLOW_BIT]))
    else $error("running source flags not one-hot");
  a_switch_when_ready: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !$stable(active_src_ff) |-> $past(target_ok))
    else $error("system clock switched to a source that was not ready");
  a_rc_switch_fast: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    sel_src == SRC_RC_FAST |=> active_src_ff == SRC_RC_FAST)
    else $error("switch to RC source took more than one cycle");
  a_write_answered: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_fire |=> s_axi_bvalid_out && !s_axi_awready_out)
    else $error("write response missing after write");
endmodule
`default_nettype wire

// [rsc_div_if.sv]
// Carrier between the clock control top and one enable divider
`default_nettype none
interface rsc_div_if;
  logic src_tick;
  logic en;
  logic [1:0] code;
  logic tick;
  modport div_side (input src_tick, input en, input code, output tick);
  modport ctl_side (output src_tick, output en, output code, input tick);
endinterface
`default_nettype wire

// [rsc_divider.sv]
// Divide-by-1/2/4/8 clock enable with boundary-aligned gating
`default_nettype none
module rsc_divider
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Control and tick
  rsc_div_if.div_side div_io
);
  logic [2:0] cnt_ff;
  logic [1:0] code_ff;
  logic en_ff;
  logic tick_ff;
  logic [2:0] lim;
  logic last;

  always_comb begin
    unique case (code_ff)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      2'h3: lim = 3'h7;
    endcase
  end
  assign last = (cnt_ff == lim);

  // Code and gate only move at a period boundary, so no pulse is cut short
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 3'h0;
      code_ff <= DIV_BY_ONE;
      en_ff <= 1'b0;
    end else if (div_io.src_tick) begin
      if (last) begin
        cnt_ff <= 3'h0;
        code_ff <= div_io.code;
        en_ff <= div_io.en;
      end else begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= div_io.src_tick && last && en_ff;
    end
  end
  assign div_io.tick = tick_ff;

  a_tick_at_boundary: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    div_io.src_tick && last && en_ff |=> div_io.tick)
    else $error("divider missed a tick at period end");
  a_tick_needs_source: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    div_io.tick |-> $past(div_io.src_tick) && $past(en_ff))
    else $error("divider ticked without source or gate");
endmodule
`default_nettype wire

// [rsc_pkg.sv]
// Shared constants for the radio and system clock control block
`default_nettype none
package rsc_pkg;
  // ****************************************
  // Register indices and bus decode
  // ****************************************
  localparam logic [31:0] RADIO_CLOCK_CTRL_IDX = 32'h5000_0008;
  localparam logic [31:0] SYSTEM_CLOCK_CTRL_IDX = 32'h5000_000A;
  localparam logic [31:0] TIMER_CLOCK_CTRL_IDX = 32'h5000_000C;
  localparam int WORD_ADDR_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [15:0] RADIO_CLOCK_CTRL_RST = 16'h0040;
  localparam logic [15:0] SYSTEM_CLOCK_CTRL_RST = 16'h0001;
  localparam logic [15:0] TIMER_CLOCK_CTRL_RST = 16'h0000;
  localparam logic [15:0] RADIO_CLOCK_CTRL_MASK = 16'h00FB;
  localparam logic [15:0] SYSTEM_CLOCK_CTRL_MASK = 16'h037F;
  localparam logic [15:0] TIMER_CLOCK_CTRL_MASK = 16'h7C00;

  // ****************************************
  // Radio clock register fields
  // ****************************************
  localparam int LINK_GATE_BIT = 7;
  localparam int LINK_LP_RESET_BIT = 6;
  localparam int LINK_DIV_LSB = 4;
  localparam int RF_GATE_BIT = 3;
  localparam int RF_DIV_LSB = 0;

  // ****************************************
  // System clock register fields
  // ****************************************
  localparam int RUN_PLL_BIT = 15;
  localparam int RUN_CRYSTAL_BIT = 14;
  localparam int RUN_RC_BIT = 13;
  localparam int RUN_SLOW_BIT = 12;
  localparam int LP_SEL_LSB = 8;
  localparam int FIXED_SIXTEEN_MHZ_CLOCK_HALVE_BIT = 6;
  localparam int PLL_HALVE_BIT = 5;
  localparam int USB_SEL_BIT = 4;
  localparam int XTAL_DIV_EN_BIT = 3;
  localparam int XTAL_OFF_BIT = 2;
  localparam int SYS_SEL_LSB = 0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h0;
  localparam logic [1:0] SRC_RC_FAST = 2'h1;
  localparam logic [1:0] SRC_LOWPOWER = 2'h2;
  localparam logic [1:0] SRC_PLL = 2'h3;

  // ****************************************
  // Timer clock register fields
  // ****************************************
  localparam int PWM_ROUTE_BIT = 14;
  localparam int WAKEUP_GATE_BIT = 13;
  localparam int BREATH_GATE_BIT = 12;
  localparam int TMR2_SEL_BIT = 11;
  localparam int TMR2_GATE_BIT = 10;
  localparam logic [1:0] DIV_BY_ONE = 2'h0;
endpackage
`default_nettype wire

// [rsc_tb.sv]
// Self-checking bench for the radio and system clock control block
`default_nettype none
module testbench
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Signals and the device
  // ****************************************
  logic sys_clk_in, rst_n_in;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic div1_tick_in, fixed_sixteen_mhz_clock_in, crystal_settled_in, pll_locked_in, lowpower_clock_ok_in;
  logic debugger_en_in, link_core_sleep_in, link_reg_access_in, hard_fault_out, link_core_clock_gate_out;
  logic link_core_tick_out, link_lowpower_timer_reset_out, rf_unit_clock_gate_out, rf_unit_tick_out;
  logic [1:0] system_clock_select_out, lowpower_clock_select_out;
  logic fixed_sixteen_mhz_clock_halve_for_big_crystal_out, pll_halve_out, usb_clock_select_out, crystal_divider_enable_out;
  logic crystal_osc_off_out, timer1_pwm_pad_route_out, timer2_tick_out;
  logic wakeup_counter_clock_gate_out, breathing_led_clock_gate_out;
  logic cnt_on = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int rf_n, link_n, t2_n;
  localparam logic [11:0] A_RADIO = 12'h020, A_SYS = 12'h028, A_TMR = 12'h030, A_NONE = 12'h040;
  rsc_clock_control u_dut (.*);

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // Tick counting window; counters clear while the window is shut
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
    if (cnt_on) begin
      rf_n <= rf_n + int'(rf_unit_tick_out);
      link_n <= link_n + int'(link_core_tick_out);
      t2_n <= t2_n + int'(timer2_tick_out);
    end else begin
      rf_n <= 0;
      link_n <= 0;
      t2_n <= 0;
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Leading edge keeps a new request off the edge that ended the last one
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk_in);
    {s_axi_awaddr_in, s_axi_wdata_in} <= {a, 16'h0000, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge sys_clk_in); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk({30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    do @(posedge sys_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge sys_clk_in); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    chk({30'h0, s_axi_rresp_out}, {30'h0, er});
    chk(s_axi_rdata_out, {16'h0000, exp});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_radio();
    rd(A_RADIO, 16'h0040);
    rd(A_SYS, 16'h2001);
    rd(A_TMR, 16'h0000);
    chk({29'h0, link_core_clock_gate_out, link_lowpower_timer_reset_out, rf_unit_clock_gate_out}, 32'h2);
    chk({30'h0, system_clock_select_out}, 32'h1);
    wr(A_RADIO, 16'hFFFF);
    rd(A_RADIO, 16'h00FB);
    chk({29'h0, link_core_clock_gate_out, link_lowpower_timer_reset_out, rf_unit_clock_gate_out}, 32'h7);
    wr(A_RADIO, 16'h0000);
    chk({29'h0, link_core_clock_gate_out, link_lowpower_timer_reset_out, rf_unit_clock_gate_out}, 32'h0);
    wr(A_NONE, 16'hFFFF, RESP_DECERR);
    rd(A_NONE, 16'h0000, RESP_DECERR);
    rd(A_RADIO, 16'h0000);
  endtask

  // Gate off, gate on and awake, gate on but asleep
  task automatic t_fault();
    for (int i = 0; i < 3; i++) begin
      wr(A_RADIO, i == 0 ? 16'h0000 : 16'h0080);
      @(posedge sys_clk_in);
      link_core_sleep_in <= (i == 2);
      link_reg_access_in <= 1'b1;
      @(posedge sys_clk_in);
      link_reg_access_in <= 1'b0;
      @(posedge sys_clk_in);
      chk({31'h0, hard_fault_out}, {31'h0, i != 1});
      @(posedge sys_clk_in);
      chk({31'h0, hard_fault_out}, 32'h0);
    end
    link_core_sleep_in <= 1'b0;
  endtask

  // Source ticks every cycle except in the halved pass c == 4, so a period of p gives 64/p ticks in 64 cycles
  task automatic t_divide();
    for (int c = 0; c < 5; c++) begin
      wr(A_SYS, c == 4 ? 16'h0041 : 16'h0001);
      wr(A_RADIO, c == 4 ? 16'h0080 : 16'h0088 | (16'(c) << 4) | 16'(c));
      wr(A_TMR, c == 4 ? 16'h0400 : 16'h0C00);
      repeat (40) @(posedge sys_clk_in);
      cnt_on <= 1'b1;
      repeat (64) @(posedge sys_clk_in);
      cnt_on <= 1'b0;
      @(negedge sys_clk_in);
      chk(rf_n, c == 4 ? 0 : 64 >> c);
      chk(link_n, c == 4 ? 32 : 64 >> c);
      chk(t2_n, c == 4 ? 32 : 64);
    end
  endtask

  task automatic t_source();
    logic [15:0] run_flag [4] = '{16'h4000, 16'h2000, 16'h1000, 16'h8000};
    wr(A_SYS, 16'h0003);
    repeat (10) @(posedge sys_clk_in);
    chk({30'h0, system_clock_select_out}, 32'h1);
    rd(A_SYS, 16'h2003);
    {pll_locked_in, crystal_settled_in, lowpower_clock_ok_in} <= 3'h7;
    // Ends on the PLL, so the crystal is idle before its stop bit is set
    for (int s = 0; s < 4; s++) begin
      wr(A_SYS, (16'(s) << 8) | 16'(s));
      repeat (6) @(posedge sys_clk_in);
      chk({30'h0, system_clock_select_out}, 32'(s));
      chk({30'h0, lowpower_clock_select_out}, 32'(s));
      rd(A_SYS, run_flag[s] | (16'(s) << 8) | 16'(s));
    end
    wr(A_SYS, 16'hFFFD);
    rd(A_SYS, 16'h237D);
    chk({25'h0, lowpower_clock_select_out, fixed_sixteen_mhz_clock_halve_for_big_crystal_out, pll_halve_out, usb_clock_select_out,
         crystal_divider_enable_out, crystal_osc_off_out}, 32'h7F);
    wr(A_SYS, 16'h0001);
    chk({25'h0, lowpower_clock_select_out, fixed_sixteen_mhz_clock_halve_for_big_crystal_out, pll_halve_out, usb_clock_select_out,
         crystal_divider_enable_out, crystal_osc_off_out}, 32'h0);
  endtask

  // Pad route only while the debugger is off; sync adds a few cycles
  task automatic t_timer();
    wr(A_TMR, 16'hFFFF);
    rd(A_TMR, 16'h7C00);
    repeat (5) @(posedge sys_clk_in);
    chk({29'h0, timer1_pwm_pad_route_out, wakeup_counter_clock_gate_out, breathing_led_clock_gate_out}, 32'h7);
    debugger_en_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    chk({31'h0, timer1_pwm_pad_route_out}, 32'h0);
    debugger_en_in <= 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    s_axi_wstrb_in = 4'hF;
    {div1_tick_in, fixed_sixteen_mhz_clock_in} = 2'h3;
    {crystal_settled_in, pll_locked_in, lowpower_clock_ok_in, debugger_en_in} = '0;
    {link_core_sleep_in, link_reg_access_in} = '0;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset_and_radio();
    t_fault();
    t_divide();
    t_source();
    t_timer();
    tally_and_finish();
  end
endmodule
`default_nettype wire
